// [core/flash_erase_map.svh]
// command codes, status bit positions and bus timing for the flash erase host
// assumes a word-wide asynchronous flash with a status byte on data bits 7..0
// What this block does
// - after status-read command, reads give status; bit 7 high means engine ready
// - bit 0 is reserved; the host masks it when polling
// - erase is setup code at any address, then confirm inside the block
// - several erasures repeat setup and confirm, waiting for ready each time
// - read-array code after the last operation returns array data
`ifndef FLASH_ERASE_MAP_SVH
`define FLASH_ERASE_MAP_SVH
`define CMD_READ_STATUS   8'h70
`define CMD_ERASE_SETUP   8'h20
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_READ_ARRAY    8'hFF
`define CMD_CLEAR_STATUS  8'h50
`define SR_READY          7
`define SR_ERASE_SUSP     6
`define SR_ERASE_ERR      5
`define SR_WRITE_ERR      4
`define SR_SUPPLY_LOW     3
`define SR_WRITE_SUSP     2
`define SR_PROTECT        1
`define SR_ERROR_MASK     8'h3A
`define SR_POLL_MASK      8'hFE
`define CLK_PERIOD_NS     10
`define BUS_PULSE_NS      70
`define BUS_PULSE_CYC     ((`BUS_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_RECOVER_NS    30
`define BUS_RECOVER_CYC   ((`BUS_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [core/flash_erase_pkg.sv]
// types for the flash erase host
// assumes flash_erase_map.svh for numbers
package flash_erase_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD_STATUS, ST_POLL_READ, ST_SETUP, ST_CONFIRM,
    ST_WAIT_READ, ST_CLEAR, ST_ARRAY, ST_DONE
  } host_state_t;
  typedef enum logic [1:0] {
    CYC_IDLE, CYC_ASSERT, CYC_RECOVER
  } cycle_state_t;
endpackage

// [core/flash_bus_cycle.sv]
// one asynchronous write or read cycle on the flash pins
// assumes pins are sampled through two flops before data is used
`timescale 1ns/100ps
`include "flash_erase_map.svh"
module flash_bus_cycle
  import flash_erase_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire logic              start_i,
  input  wire logic              write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [15:0]       wdata_i,
  output logic                   done_o,
  output logic [15:0]            rdata_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [15:0]            flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [15:0]       flash_dq_i,
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o
);
  typedef struct packed {
    cycle_state_t        st;
    logic [7:0]          cnt;
    logic                wr;
    logic [ADDR_W-1:0]   addr;
    logic [15:0]         wdata;
    logic [15:0]         rdata;
    logic [15:0]         dq_s1;
    logic [15:0]         dq_s2;
    logic                done;
  } cyc_t;
  cyc_t s_reg, s_next;
  localparam logic [7:0] PULSE   = 8'(`BUS_PULSE_CYC);
  localparam logic [7:0] RECOVER = 8'(`BUS_RECOVER_CYC);
  if (ADDR_W < 1 || ADDR_W > 32) begin
    $error("ADDR_W out of range");
  end
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.dq_s1 = flash_dq_i;
    s_next.dq_s2 = s_reg.dq_s1;
    case (s_reg.st)
      CYC_IDLE: begin
        if (start_i) begin
          s_next.st = CYC_ASSERT;
          s_next.wr = write_i;
          s_next.addr = addr_i;
          s_next.wdata = wdata_i;
          s_next.cnt = PULSE + 8'h02;
        end
      end
      CYC_ASSERT: begin
        // two extra cycles let read data clear the synchroniser
        if (s_reg.cnt == 8'h00) begin
          s_next.rdata = s_reg.dq_s2;
          s_next.st = CYC_RECOVER;
          s_next.cnt = RECOVER;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      default: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.st = CYC_IDLE;
          s_next.done = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign done_o        = s_reg.done;
  assign rdata_o       = s_reg.rdata;
  assign flash_addr_o  = s_reg.addr;
  assign flash_dq_o    = s_reg.wdata;
  assign flash_dq_oe_o = (s_reg.st != CYC_IDLE) && s_reg.wr;
  assign flash_ce_n_o  = (s_reg.st == CYC_IDLE);
  assign flash_we_n_o  = !((s_reg.st == CYC_ASSERT) && s_reg.wr);
  assign flash_oe_n_o  = !((s_reg.st == CYC_ASSERT) && !s_reg.wr);
endmodule

// [core/flash_erase_host.sv]
// host sequencer: block erase, status polling, error clear, read array
// assumes the flash pins connect straight to the device; dq is three-state outside
`timescale 1ns/100ps
`include "flash_erase_map.svh"
module flash_erase_host
  import flash_erase_pkg::*;
#(
  parameter int ADDR_W     = 20,
  parameter int POLL_LIMIT = 1000000
) (
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire logic              erase_req_i,
  input  wire logic [ADDR_W-1:0] erase_addr_i,
  input  wire logic              clear_req_i,
  input  wire logic              array_req_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [7:0]             status_o,
  output logic                   erase_err_o,
  output logic                   seq_err_o,
  output logic                   supply_err_o,
  output logic                   protect_err_o,
  output logic                   timeout_o,
  output logic                   powerdown_reset_n_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [15:0]            flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [15:0]       flash_dq_i,
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o
);
  typedef struct packed {
    host_state_t       st;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        status;
    logic [31:0]       polls;
    logic              issued;
    logic              done;
    logic              timeout;
    logic              seq_err;
    logic              erase_err;
    logic              supply_err;
    logic              protect_err;
  } host_t;
  host_t s_reg, s_next;
  logic              cyc_start;
  logic              cyc_write;
  logic [ADDR_W-1:0] cyc_addr;
  logic [15:0]       cyc_wdata;
  logic              cyc_done;
  logic [15:0]       cyc_rdata;
  if (ADDR_W < 1 || ADDR_W > 32) begin
    $error("ADDR_W out of range");
  end
  if (POLL_LIMIT < 1) begin
    $error("POLL_LIMIT must be positive");
  end
  flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clk_sys_i     (clk_sys_i),
    .srst_i        (srst_i),
    .start_i       (cyc_start),
    .write_i       (cyc_write),
    .addr_i        (cyc_addr),
    .wdata_i       (cyc_wdata),
    .done_o        (cyc_done),
    .rdata_o       (cyc_rdata),
    .flash_addr_o  (flash_addr_o),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_o (flash_dq_oe_o),
    .flash_dq_i    (flash_dq_i),
    .flash_ce_n_o  (flash_ce_n_o),
    .flash_oe_n_o  (flash_oe_n_o),
    .flash_we_n_o  (flash_we_n_o)
  );
  function automatic logic [15:0] cmd_word(input logic [7:0] c);
    cmd_word = {8'h00, c};
  endfunction
  // reserved bit is dropped here so no caller can poll on it
  function automatic logic [7:0] status_of(input logic [15:0] d);
    status_of = d[7:0] & `SR_POLL_MASK;
  endfunction
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    cyc_start = 1'b0;
    cyc_write = 1'b1;
    cyc_addr = '0;
    cyc_wdata = 16'h0000;
    case (s_reg.st)
      ST_IDLE: begin
        // erase wins over clear and clear over array when several arrive together
        s_next.issued = 1'b0;
        if (erase_req_i) begin
          s_next.addr = erase_addr_i;
          s_next.polls = 32'h0;
          s_next.timeout = 1'b0;
          s_next.st = ST_CMD_STATUS;
        end else if (clear_req_i) begin
          s_next.st = ST_CLEAR;
        end else if (array_req_i) begin
          s_next.st = ST_ARRAY;
        end
      end
      ST_CMD_STATUS: begin
        // issued turns start into a one-cycle pulse per bus cycle
        cyc_wdata = cmd_word(`CMD_READ_STATUS);
        cyc_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (cyc_done) begin
          s_next.issued = 1'b0;
          s_next.st = ST_POLL_READ;
        end
      end
      ST_POLL_READ: begin
        // wait for ready before each erase
        cyc_write = 1'b0;
        cyc_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (cyc_done) begin
          s_next.issued = 1'b0;
          s_next.status = status_of(cyc_rdata);
          s_next.polls = s_reg.polls + 32'h1;
          // a device that never turns ready would hang the host, so give up after the limit
          if (cyc_rdata[`SR_READY]) begin
            s_next.st = ST_SETUP;
          end else if (s_reg.polls >= 32'(POLL_LIMIT)) begin
            s_next.timeout = 1'b1;
            s_next.st = ST_DONE;
          end
        end
      end
      ST_SETUP: begin
        cyc_wdata = cmd_word(`CMD_ERASE_SETUP);
        cyc_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (cyc_done) begin
          s_next.issued = 1'b0;
          s_next.st = ST_CONFIRM;
        end
      end
      ST_CONFIRM: begin
        // only the confirm carries the block address; the setup went to address zero
        cyc_addr = s_reg.addr;
        cyc_wdata = cmd_word(`CMD_ERASE_CONFIRM);
        cyc_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (cyc_done) begin
          s_next.issued = 1'b0;
          s_next.polls = 32'h0;
          s_next.st = ST_WAIT_READ;
        end
      end
      ST_WAIT_READ: begin
        // device stays in status mode, so no new status command is needed
        cyc_write = 1'b0;
        cyc_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (cyc_done) begin
          s_next.issued = 1'b0;
          s_next.status = status_of(cyc_rdata);
          s_next.polls = s_reg.polls + 32'h1;
          // ready ends the erase; the copy keeps its error bits for the caller
          if (cyc_rdata[`SR_READY]) begin
            s_next.st = ST_DONE;
          end else if (s_reg.polls >= 32'(POLL_LIMIT)) begin
            s_next.timeout = 1'b1;
            s_next.st = ST_DONE;
          end
        end
      end
      ST_CLEAR: begin
        cyc_wdata = cmd_word(`CMD_CLEAR_STATUS);
        cyc_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (cyc_done) begin
          // mirror the device: only the sticky error bits drop, ready stays as last read
          s_next.issued = 1'b0;
          s_next.status = s_reg.status & ~`SR_ERROR_MASK;
          s_next.st = ST_DONE;
        end
      end
      ST_ARRAY: begin
        // the status copy is kept; reads after this return array words, not status
        cyc_wdata = cmd_word(`CMD_READ_ARRAY);
        cyc_start = !s_reg.issued;
        s_next.issued = 1'b1;
        if (cyc_done) begin
          s_next.issued = 1'b0;
          s_next.st = ST_DONE;
        end
      end
      default: begin
        s_next.done = 1'b1;
        s_next.st = ST_IDLE;
      end
    endcase
    // flags are registered beside the status copy so both move on the same edge
    s_next.seq_err     = s_next.status[`SR_ERASE_ERR] && s_next.status[`SR_WRITE_ERR];
    s_next.erase_err   = s_next.status[`SR_ERASE_ERR] && !s_next.status[`SR_WRITE_ERR];
    s_next.supply_err  = s_next.status[`SR_SUPPLY_LOW];
    s_next.protect_err = s_next.status[`SR_PROTECT];
  end
  // synchronous reset only; every field, the status copy included, returns to zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign busy_o              = (s_reg.st != ST_IDLE);
  assign done_o              = s_reg.done;
  assign status_o            = s_reg.status;
  assign seq_err_o           = s_reg.seq_err;
  assign erase_err_o         = s_reg.erase_err;
  assign supply_err_o        = s_reg.supply_err;
  assign protect_err_o       = s_reg.protect_err;
  assign timeout_o           = s_reg.timeout;
  // the host holds the device in power-down only while srst_i is high
  assign powerdown_reset_n_o = !srst_i;
endmodule

// [tb/flash_erase_host_monitor.sv]
// checker for the flash erase host ports
// assumes bind from the bench top; one clock domain
`timescale 1ns/100ps
module flash_erase_host_monitor (
  input wire logic       clk_sys_i,
  input wire logic       srst_i,
  input wire logic       erase_req_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic [7:0] status_o,
  input wire logic       erase_err_o,
  input wire logic       seq_err_o,
  input wire logic       supply_err_o,
  input wire logic       protect_err_o,
  input wire logic       flash_dq_oe_o,
  input wire logic       flash_ce_n_o,
  input wire logic       flash_oe_n_o,
  input wire logic       flash_we_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  req_start_a: assert property (erase_req_i && !busy_o |=> busy_o)
    else $error("erase request not taken");
  pins_idle_a: assert property (disable iff (1'b0) srst_i |=> flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o)
    else $error("pins active in reset");
  mask_bit0_a: assert property (status_o[0] == 1'b0)
    else $error("reserved bit not masked");
  seq_err_a: assert property (seq_err_o == (status_o[5] && status_o[4]))
    else $error("sequence error decode");
  erase_err_a: assert property (erase_err_o == (status_o[5] && !status_o[4]))
    else $error("erase error decode");
  supply_flag_a: assert property (supply_err_o == status_o[3] && protect_err_o == status_o[1])
    else $error("supply or protect decode");
  we_pulse_a: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o[*7])
    else $error("write pulse too short");
  no_clash_a: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o)
    else $error("read overlaps write");
  write_sel_a: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o)
    else $error("write without select");
  done_once_a: assert property (done_o |=> !done_o)
    else $error("done longer than a cycle");
  cover property (done_o && seq_err_o);
  cover property (done_o && erase_err_o);
  cover property (done_o && status_o == 8'h80);
endmodule

// [tb/flash_device_model.sv]
// behavioural flash device: status byte, block erase, clear, read array
// assumes pins straight from the host; no clock of its own
`timescale 1ns/100ps
module flash_device_model #(
  parameter int ADDR_W = 20
) (
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [15:0]       dq_i,
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic              powerdown_reset_n_i,
  input  wire logic [7:0]        fail_bits_i,
  input  wire logic              bad_confirm_i,
  input  wire logic [3:0]        busy_reads_i,
  output logic [15:0]            dq_o,
  output logic [7:0]             last_cmd_o,
  output logic [ADDR_W-1:0]      last_addr_o
);
  logic [7:0] status_reg = 8'h80;
  logic       status_mode = 1'b0;
  logic       setup_seen = 1'b0;
  logic [3:0] busy_cnt = 4'h0;
  initial dq_o = 16'h5A5A;
  initial last_cmd_o = 8'h00;
  always @(negedge powerdown_reset_n_i) begin
    status_reg = 8'h80;
    status_mode = 1'b0;
    setup_seen = 1'b0;
    busy_cnt = 4'h0;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && powerdown_reset_n_i) begin
      last_cmd_o = dq_i[7:0];
      last_addr_o = addr_i;
      status_mode = dq_i[7:0] != 8'hFF;
      if (setup_seen && dq_i[7:0] == 8'hD0 && !bad_confirm_i) begin
        busy_cnt = busy_reads_i;
        status_reg[7] = busy_reads_i == 4'h0;
        status_reg = status_reg | (fail_bits_i & 8'h3A);
      end else if (setup_seen)
        status_reg[5:4] = 2'b11;
      else if (dq_i[7:0] == 8'h50)
        status_reg = status_reg & 8'hC5;
      setup_seen = !setup_seen && dq_i[7:0] == 8'h20;
    end
  end
  // never suspended here, so bits 6 and 2 stay low
  always @(posedge oe_n_i) begin
    if (busy_cnt != 4'h0) begin
      busy_cnt = busy_cnt - 4'h1;
      status_reg[7] = busy_cnt == 4'h0;
    end
  end
  // reserved bit and upper byte carry junk; released bus toggles so stale data never passes
  always @(ce_n_i or oe_n_i or status_reg or status_mode)
    if (!ce_n_i && !oe_n_i)
      dq_o = status_mode ? {8'h6E, status_reg | 8'h01} : 16'hC3A5;
    else
      dq_o = ~dq_o;
endmodule

// [tb/flash_erase_host_bench.sv]
// bench for the flash erase host against a behavioural flash device
// assumes the checker is bound below; one 100 MHz clock
`timescale 1ns/100ps
module flash_erase_host_bench;
  logic        clk_sys_i = 1'b0, srst_i = 1'b1, erase_req_i = 1'b0, clear_req_i = 1'b0, array_req_i = 1'b0;
  logic        busy_o, done_o, erase_err_o, seq_err_o, supply_err_o, protect_err_o, timeout_o;
  logic        powerdown_reset_n_o, flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
  logic        bad_confirm = 1'b0;
  logic [3:0]  busy_reads = 4'h1;
  logic [7:0]  status_o, last_cmd, exp_now, fail_bits = 8'h00;
  logic [19:0] erase_addr_i = 20'h00000, flash_addr_o, last_addr;
  logic [15:0] flash_dq_o, model_dq, dq_wire;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0, comparisons = 0, cycles = 0, seed = 32'h1fe2;
  int          kinds[11] = '{0, 0, 0, 1, 0, 1, 3, 1, 2, 0, 4};
  logic [7:0]  fails[11] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  logic [7:0]  exps[11] = '{8'h80, 8'hA0, 8'hA0, 8'h80, 8'h8A, 8'h80, 8'hB0, 8'h80, 8'h80, 8'h90, 8'h10};
  assign dq_wire = flash_dq_oe_o ? flash_dq_o : model_dq;
  always #5 clk_sys_i = ~clk_sys_i;
  flash_erase_host #(.ADDR_W(20), .POLL_LIMIT(4)) i_dut (.clk_sys_i, .srst_i, .erase_req_i, .erase_addr_i,
    .clear_req_i, .array_req_i, .busy_o, .done_o, .status_o, .erase_err_o, .seq_err_o, .supply_err_o,
    .protect_err_o, .timeout_o, .powerdown_reset_n_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o,
    .flash_dq_i(dq_wire), .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o);
  flash_device_model #(.ADDR_W(20)) i_flash (.addr_i(flash_addr_o), .dq_i(flash_dq_o), .ce_n_i(flash_ce_n_o),
    .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .powerdown_reset_n_i(powerdown_reset_n_o),
    .fail_bits_i(fail_bits), .bad_confirm_i(bad_confirm), .busy_reads_i(busy_reads), .dq_o(model_dq),
    .last_cmd_o(last_cmd), .last_addr_o(last_addr));
  task automatic check(input logic [19:0] seen, input logic [19:0] expected);
    comparisons++;
    if (seen !== expected) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // kind: 0 erase, 1 clear, 2 read array, 3 erase refused by the device, 4 erase that outlasts the poll limit
  task automatic op(input int kind, input logic [7:0] fail, input logic [7:0] exp_status);
    int k;
    erase_addr_i = 20'($random(seed));
    busy_reads = kind == 4 ? 4'hF : 4'($random(seed) & 3) + 4'h1;
    fail_bits = fail;
    bad_confirm = kind == 3;
    exp_q.push_back(exp_status);
    erase_req_i = kind == 0 || kind == 3 || kind == 4;
    clear_req_i = kind == 1;
    array_req_i = kind == 2;
    @(posedge clk_sys_i);
    #1;
    {erase_req_i, clear_req_i, array_req_i} = 3'b000;
    k = 0;
    while (done_o !== 1'b1 && k < 2000) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    if (k == 2000)
      n_mismatch++;
    check({12'h000, last_cmd}, {12'h000, kind == 1 ? 8'h50 : kind == 2 ? 8'hFF : 8'hD0});
    if (kind == 0)
      check(last_addr, erase_addr_i);
    check({19'h00000, timeout_o}, {19'h00000, kind == 4});
    @(posedge clk_sys_i);
    #1;
  endtask
  // done is sampled mid-cycle so the registered pulse is settled
  always @(negedge clk_sys_i)
    if (done_o === 1'b1) begin
      exp_now = exp_q.pop_front();
      check({12'h000, status_o}, {12'h000, exp_now});
      check({18'h00000, seq_err_o, erase_err_o}, {18'h00000, exp_now[5] & exp_now[4], exp_now[5] & !exp_now[4]});
      check({18'h00000, supply_err_o, protect_err_o}, {18'h00000, exp_now[3], exp_now[1]});
    end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    for (int i = 0; i < 11; i++)
      op(kinds[i], fails[i], exps[i]);
    srst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    op(0, 8'h00, 8'h80);
    @(posedge clk_sys_i);
    results();
  end
endmodule
bind flash_erase_host flash_erase_host_monitor i_mon (.clk_sys_i, .srst_i, .erase_req_i, .busy_o, .done_o,
  .status_o, .erase_err_o, .seq_err_o, .supply_err_o, .protect_err_o, .flash_dq_oe_o, .flash_ce_n_o,
  .flash_oe_n_o, .flash_we_n_o);
